// file: design/power_status_top.sv
`timescale 1ns/1ps
module power_status_top
	import power_status_pkg::*;
#(
	parameter int NPDO = 7,
	parameter int V_W = 16,
	parameter int P_W = 16
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [DATA_W/8-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Type-C state machine
	input wire logic plug_detected,
	input wire logic [STATE_W-1:0] connection_state_code,
	input wire logic present_power_role,
	input wire logic [CUR_W-1:0] cc_pullup_level,
	input wire logic [CUR_W-1:0] advertised_current_setting,
	// Charger engines
	input wire logic [DET_W-1:0] charger_detect_code,
	input wire logic [ADV_W-1:0] charger_advertise_code,
	// Sink negotiation
	input wire logic sel_start,
	input wire logic [NPDO-1:0] pdo_valid,
	input wire logic [NPDO*TYPE_W-1:0] pdo_type,
	input wire logic [NPDO*V_W-1:0] pdo_volt,
	input wire logic [NPDO*P_W-1:0] pdo_power,
	input wire logic [V_W-1:0] min_volt,
	input wire logic [V_W-1:0] max_volt,
	// Interrupt
	output logic irq
);
	localparam int IW = $clog2(NPDO);

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [DATA_W-1:0] rdata_q;
	logic [1:0] rresp_q;
	logic irq_q;
	logic aw_full_q;
	logic w_full_q;
	logic [IDX_W-1:0] waddr_q;
	logic [DATA_W-1:0] wdata_q;
	logic [DATA_W/8-1:0] wstrb_q;
	logic wr_fire;
	logic rd_fire;
	logic [IDX_W-1:0] ridx;
	logic [DATA_W-1:0] rd_d;
	logic [1:0] rresp_d;
	logic prio_q;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] int_status_q;
	logic [EV_W-1:0] int_status_d;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] int_clr;
	logic [PS_W-1:0] power_status_q;
	logic plug_q;
	logic conn_now;
	logic cur_load;
	logic [CUR_W-1:0] cur_src;
	logic [DET_W-1:0] det_q;
	logic [ADV_W-1:0] adv_q;
	logic det_ok;
	logic adv_ok;
	logic sel_done;
	logic sel_found;
	logic [IW-1:0] sel_index;
	logic sel_found_q;
	logic [IW-1:0] sel_index_q;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign irq = irq_q;

	// The plug level comes straight from the connector, so it is filtered first.
	input_sync u_plug_sync
	(
		.clk(clk),
		.arst_n(arst_n),
		.din(plug_detected),
		.dout_q(plug_q)
	);

	pdo_selector #(
		.NPDO(NPDO),
		.V_W(V_W),
		.P_W(P_W),
		.IW(IW)
	) u_selector
	(
		.clk(clk),
		.arst_n(arst_n),
		.start(sel_start),
		.prio_lower(prio_q),
		.pdo_valid(pdo_valid),
		.pdo_type(pdo_type),
		.pdo_volt(pdo_volt),
		.pdo_power(pdo_power),
		.min_volt(min_volt),
		.max_volt(max_volt),
		.done_q(sel_done),
		.found_q(sel_found),
		.index_q(sel_index)
	);

	// Write channel: address and data are taken in either order, the response follows both.
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && awready_q)
			begin
				aw_full_q <= 1'b1;
				awready_q <= 1'b0;
				waddr_q <= s_axi_awaddr[ADDR_W-1:2];
			end
			else if (!aw_full_q && !bvalid_q)
				awready_q <= 1'b1;
			if (s_axi_wvalid && wready_q)
			begin
				w_full_q <= 1'b1;
				wready_q <= 1'b0;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			else if (!w_full_q && !bvalid_q)
				wready_q <= 1'b1;
			if (wr_fire)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				bvalid_q <= 1'b1;
				if (waddr_q == IDX_POWER_STATUS || waddr_q == IDX_CFG || waddr_q == IDX_INT_STATUS
					|| waddr_q == IDX_INT_MASK || waddr_q == IDX_SEL_RESULT)
					bresp_q <= RESP_OKAY;
				else
					bresp_q <= RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end

	// Only the configuration and mask registers take writes; read-only words accept and drop them.
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			prio_q <= CFG_PRIO_RESET;
			mask_q <= '0;
		end
		else if (wr_fire && wstrb_q[0])
		begin
			if (waddr_q == IDX_CFG)
				prio_q <= wdata_q[CFG_PRIO_BIT];
			else if (waddr_q == IDX_INT_MASK)
				mask_q <= wdata_q[EV_W-1:0];
		end

	// Read channel: one read in flight, answered the cycle after the address is taken.
	assign rd_fire = s_axi_arvalid && arready_q;
	assign ridx = s_axi_araddr[ADDR_W-1:2];

	always_comb
	begin
		rd_d = '0;
		rresp_d = RESP_OKAY;
		if (ridx == IDX_POWER_STATUS)
			rd_d[PS_W-1:0] = power_status_q;
		else if (ridx == IDX_CFG)
			rd_d[CFG_PRIO_BIT] = prio_q;
		else if (ridx == IDX_INT_STATUS)
			rd_d[EV_W-1:0] = int_status_q;
		else if (ridx == IDX_INT_MASK)
			rd_d[EV_W-1:0] = mask_q;
		else if (ridx == IDX_SEL_RESULT)
		begin
			rd_d[IW-1:0] = sel_index_q;
			rd_d[SEL_FOUND_BIT] = sel_found_q;
		end
		else
			rresp_d = RESP_SLVERR;
	end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q <= rd_d;
			rresp_q <= rresp_d;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
		else if (!rvalid_q)
			arready_q <= 1'b1;

	// Power status fields.
	assign conn_now = plug_q && (connection_state_code > CONN_STATE_MIN);
	assign cur_src = present_power_role ? cc_pullup_level : advertised_current_setting;
	// As source the field is frozen once connected; it loads on the connecting edge.
	assign cur_load = present_power_role || !conn_now || !power_status_q[PS_CONN_BIT];
	// Reserved codes are never reported; the previous code is held instead.
	assign det_ok = charger_detect_code <= DET_LAST;
	assign adv_ok = charger_advertise_code != ADV_RSVD;

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			power_status_q <= PS_RESET;
		else
		begin
			power_status_q[PS_CONN_BIT] <= conn_now;
			power_status_q[PS_ROLE_BIT] <= present_power_role;
			if (cur_load)
				power_status_q[PS_CUR_LSB +: CUR_W] <= cur_src;
			if (det_ok)
				power_status_q[PS_DET_LSB +: DET_W] <= charger_detect_code;
			if (adv_ok)
				power_status_q[PS_ADV_LSB +: ADV_W] <= charger_advertise_code;
		end

	always_comb
	begin
		det_q = power_status_q[PS_DET_LSB +: DET_W];
		adv_q = power_status_q[PS_ADV_LSB +: ADV_W];
	end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			sel_found_q <= 1'b0;
			sel_index_q <= '0;
		end
		else if (sel_done)
		begin
			sel_found_q <= sel_found;
			sel_index_q <= sel_index;
		end

	// Events and interrupt; a set in the clearing cycle survives the read.
	always_comb
	begin
		events = '0;
		events[EV_CONN] = conn_now != power_status_q[PS_CONN_BIT];
		events[EV_ROLE] = present_power_role != power_status_q[PS_ROLE_BIT];
		events[EV_DET] = det_ok && charger_detect_code >= DET_NONE && charger_detect_code != det_q;
		events[EV_ADV] = charger_advertise_code == ADV_DONE && adv_q != ADV_DONE;
		events[EV_SEL] = sel_done;
		int_clr = (rd_fire && ridx == IDX_INT_STATUS) ? {EV_W{1'b1}} : {EV_W{1'b0}};
		int_status_d = (int_status_q & ~int_clr) | events;
	end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			int_status_q <= '0;
			irq_q <= 1'b0;
		end
		else
		begin
			int_status_q <= int_status_d;
			irq_q <= |(int_status_d & mask_q);
		end
endmodule // power_status_top

// file: design/power_status_pkg.sv
package power_status_pkg;

	// Word address: the printed offset is a register index, byte address is index times four.
	localparam int ADDR_W = 10;
	localparam int IDX_W = 8;
	localparam int DATA_W = 32;
	localparam logic [IDX_W-1:0] IDX_POWER_STATUS = 8'h3F;
	localparam logic [IDX_W-1:0] IDX_CFG = 8'h20;
	localparam logic [IDX_W-1:0] IDX_INT_STATUS = 8'h21;
	localparam logic [IDX_W-1:0] IDX_INT_MASK = 8'h22;
	localparam logic [IDX_W-1:0] IDX_SEL_RESULT = 8'h23;

	// Power status register layout.
	localparam int PS_W = 16;
	localparam logic [PS_W-1:0] PS_RESET = 16'h0000;
	localparam int PS_CONN_BIT = 0;
	localparam int PS_ROLE_BIT = 1;
	localparam int PS_CUR_LSB = 2;
	localparam int PS_DET_LSB = 4;
	localparam int PS_ADV_LSB = 8;
	localparam int CUR_W = 2;
	localparam int DET_W = 4;
	localparam int ADV_W = 2;
	localparam int STATE_W = 4;
	localparam logic [STATE_W-1:0] CONN_STATE_MIN = 4'h5;

	// Type-C current codes.
	localparam logic [CUR_W-1:0] CUR_DEFAULT = 2'h0;
	localparam logic [CUR_W-1:0] CUR_1A5 = 2'h1;
	localparam logic [CUR_W-1:0] CUR_3A0 = 2'h2;
	localparam logic [CUR_W-1:0] CUR_PD = 2'h3;

	// Charger advertise and detect codes.
	localparam logic [ADV_W-1:0] ADV_OFF = 2'h0;
	localparam logic [ADV_W-1:0] ADV_BUSY = 2'h1;
	localparam logic [ADV_W-1:0] ADV_DONE = 2'h2;
	localparam logic [ADV_W-1:0] ADV_RSVD = 2'h3;
	localparam logic [DET_W-1:0] DET_OFF = 4'h0;
	localparam logic [DET_W-1:0] DET_BUSY = 4'h1;
	localparam logic [DET_W-1:0] DET_NONE = 4'h2;
	localparam logic [DET_W-1:0] DET_LAST = 4'h9;

	// Supply types of a power object and their preference rank.
	localparam int TYPE_W = 2;
	localparam logic [TYPE_W-1:0] PDO_FIXED = 2'h0;
	localparam logic [TYPE_W-1:0] PDO_BATTERY = 2'h1;
	localparam logic [TYPE_W-1:0] PDO_VARIABLE = 2'h2;
	localparam logic [TYPE_W-1:0] PDO_AUGMENTED = 2'h3;
	localparam logic [1:0] RANK_FIXED = 2'h2;
	localparam logic [1:0] RANK_VARIABLE = 2'h1;
	localparam logic [1:0] RANK_OTHER = 2'h0;

	// Configuration, interrupt and selection result layouts.
	localparam int CFG_PRIO_BIT = 0;
	localparam logic CFG_PRIO_RESET = 1'b0;
	localparam int EV_CONN = 0;
	localparam int EV_ROLE = 1;
	localparam int EV_DET = 2;
	localparam int EV_ADV = 3;
	localparam int EV_SEL = 4;
	localparam int EV_W = 5;
	localparam int SEL_FOUND_BIT = 8;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: design/input_sync.sv
`timescale 1ns/1ps
module input_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Asynchronous level in, filtered level out
	input wire logic din,
	output logic dout_q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end
		else
		begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end

	// A change is taken only once two later stages agree, so a glitch in the middle stage is ignored.
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
			dout_q <= 1'b0;
		else if (s2_q == s3_q)
			dout_q <= s3_q;
endmodule // input_sync

// file: design/pdo_selector.sv
`timescale 1ns/1ps
module pdo_selector
	import power_status_pkg::*;
#(
	parameter int NPDO = 7,
	parameter int V_W = 16,
	parameter int P_W = 16,
	parameter int IW = $clog2(NPDO)
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Control
	input wire logic start,
	input wire logic prio_lower,
	// Offered objects, entry i in slice i
	input wire logic [NPDO-1:0] pdo_valid,
	input wire logic [NPDO*TYPE_W-1:0] pdo_type,
	input wire logic [NPDO*V_W-1:0] pdo_volt,
	input wire logic [NPDO*P_W-1:0] pdo_power,
	// Voltage requirement
	input wire logic [V_W-1:0] min_volt,
	input wire logic [V_W-1:0] max_volt,
	// Result
	output logic done_q,
	output logic found_q,
	output logic [IW-1:0] index_q
);
	typedef enum logic {SEL_IDLE, SEL_SCAN} sel_state_t;

	localparam logic [IW-1:0] LAST = IW'(NPDO - 1);

	sel_state_t state_q;
	logic [IW-1:0] idx_q;
	logic [P_W-1:0] best_power_q;
	logic [1:0] best_rank_q;
	logic [V_W-1:0] best_volt_q;
	logic [TYPE_W-1:0] cur_type;
	logic [V_W-1:0] cur_volt;
	logic [P_W-1:0] cur_power;
	logic [1:0] cur_rank;
	logic fits;
	logic better;

	always_comb
	begin
		cur_type = pdo_type[idx_q*TYPE_W +: TYPE_W];
		cur_volt = pdo_volt[idx_q*V_W +: V_W];
		cur_power = pdo_power[idx_q*P_W +: P_W];
		if (cur_type == PDO_FIXED)
			cur_rank = RANK_FIXED;
		else if (cur_type == PDO_VARIABLE)
			cur_rank = RANK_VARIABLE;
		else
			cur_rank = RANK_OTHER;
		fits = pdo_valid[idx_q] && cur_volt >= min_volt && cur_volt <= max_volt;
		if (!found_q || cur_power > best_power_q)
			better = 1'b1;
		else if (cur_power < best_power_q)
			better = 1'b0;
		else if (cur_rank != best_rank_q)
			better = cur_rank > best_rank_q;
		else if (prio_lower)
			better = cur_volt < best_volt_q;
		else
			better = cur_volt > best_volt_q;
	end

	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			state_q <= SEL_IDLE;
			idx_q <= '0;
			done_q <= 1'b0;
		end
		else
		begin
			done_q <= 1'b0;
			case (state_q)
				SEL_IDLE:
					if (start)
					begin
						idx_q <= '0;
						state_q <= SEL_SCAN;
					end
				SEL_SCAN:
					if (idx_q == LAST)
					begin
						done_q <= 1'b1;
						state_q <= SEL_IDLE;
					end
					else
						idx_q <= idx_q + 1'b1;
				default:
					state_q <= SEL_IDLE;
			endcase
		end

	// The best candidate so far; a new scan forgets the previous winner.
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n)
		begin
			found_q <= 1'b0;
			index_q <= '0;
			best_power_q <= '0;
			best_rank_q <= RANK_OTHER;
			best_volt_q <= '0;
		end
		else if (state_q == SEL_IDLE && start)
			found_q <= 1'b0;
		else if (state_q == SEL_SCAN && fits && better)
		begin
			found_q <= 1'b1;
			index_q <= idx_q;
			best_power_q <= cur_power;
			best_rank_q <= cur_rank;
			best_volt_q <= cur_volt;
		end
endmodule // pdo_selector

// file: dv/power_status_props.sv
`timescale 1ns/1ps
module power_status_props
	import power_status_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Register bus
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Type-C state
	input wire logic [STATE_W-1:0] connection_state_code,
	input wire logic present_power_role,
	input wire logic [CUR_W-1:0] cc_pullup_level
);
	logic rd_ps_q;
	logic wr_ps_q;
	// Remember whether the transfer under way targets the power status word.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_ps_q <= 1'b0;
			wr_ps_q <= 1'b0;
		end
		else
		begin
			if (s_axi_arvalid && s_axi_arready)
				rd_ps_q <= s_axi_araddr[9:2] == IDX_POWER_STATUS;
			if (s_axi_awvalid && s_axi_awready)
				wr_ps_q <= s_axi_awaddr[9:2] == IDX_POWER_STATUS;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_rsv;
		s_axi_rvalid && rd_ps_q |-> s_axi_rdata[31:10] == 22'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved status bits set");
	property p_adv;
		s_axi_rvalid && rd_ps_q |-> s_axi_rdata[9:8] != ADV_RSVD;
	endproperty
	a_adv: assert property (p_adv) else $error("advertise field reserved code");
	property p_det;
		s_axi_rvalid && rd_ps_q |-> s_axi_rdata[7:4] <= DET_LAST;
	endproperty
	a_det: assert property (p_det) else $error("detect field out of range");
	property p_role;
		$rose(s_axi_rvalid) && rd_ps_q |-> s_axi_rdata[1] == $past(present_power_role, 2);
	endproperty
	a_role: assert property (p_role) else $error("role bit differs from role");
	property p_conn;
		$rose(s_axi_rvalid) && rd_ps_q && s_axi_rdata[0] |-> $past(connection_state_code, 2) > CONN_STATE_MIN;
	endproperty
	a_conn: assert property (p_conn) else $error("connection bit with low state");
	property p_cur;
		$rose(s_axi_rvalid) && rd_ps_q && s_axi_rdata[1] |-> s_axi_rdata[3:2] == $past(cc_pullup_level, 2);
	endproperty
	a_cur: assert property (p_cur) else $error("sink current differs from pull-up");
	property p_wr;
		s_axi_bvalid && wr_ps_q |-> s_axi_bresp == RESP_OKAY;
	endproperty
	a_wr: assert property (p_wr) else $error("status write not answered okay");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	property p_ar;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_ar: assert property (p_ar) else $error("read answer late");
endmodule // power_status_props

bind power_status_top power_status_props u_props (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .connection_state_code,
	.present_power_role, .cc_pullup_level);

// file: dv/port_partner_model.sv
`timescale 1ns/1ps
module port_partner_model
	import power_status_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Bench commands
	input wire logic attach,
	input wire logic provide,
	input wire logic [STATE_W-1:0] top_state,
	input wire logic [CUR_W-1:0] pull_cmd,
	// Type-C view of the partner
	output logic plug_detected,
	output logic [STATE_W-1:0] connection_state_code,
	output logic present_power_role,
	output logic [CUR_W-1:0] cc_pullup_level
);
	// The plug pin is asynchronous, so it moves off the clock grid.
	assign #37 plug_detected = attach;
	// One step a cycle, so every code below the target is seen on the way up.
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			connection_state_code <= 4'h0;
		else if (!attach)
			connection_state_code <= 4'h0;
		else if (connection_state_code < top_state)
			connection_state_code <= connection_state_code + 4'h1;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			present_power_role <= 1'b0;
			cc_pullup_level <= 2'h0;
		end
		else
		begin
			present_power_role <= attach && provide;
			cc_pullup_level <= attach ? pull_cmd : 2'h0;
		end
	end
endmodule // port_partner_model

// file: dv/power_status_top_tb_top.sv
`timescale 1ns/1ps
module power_status_top_tb_top;
	import power_status_pkg::*;
	localparam int N = 7;
	localparam logic [9:0] A_PS = {IDX_POWER_STATUS, 2'h0};
	localparam logic [9:0] A_CFG = {IDX_CFG, 2'h0};
	localparam logic [9:0] A_IST = {IDX_INT_STATUS, 2'h0};
	localparam logic [9:0] A_IMK = {IDX_INT_MASK, 2'h0};
	localparam logic [9:0] A_SEL = {IDX_SEL_RESULT, 2'h0};
	localparam logic [15:0] VT [4] = '{16'h0BB8, 16'h1388, 16'h2328, 16'h4E20};
	logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq, sel_start;
	logic plug_detected, present_power_role, attach, provide, slow_rd;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, ed;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, ea;
	logic [STATE_W-1:0] connection_state_code, top_state, charger_detect_code;
	logic [CUR_W-1:0] cc_pullup_level, advertised_current_setting, pull_cmd, charger_advertise_code;
	logic [N-1:0] pdo_valid;
	logic [N*2-1:0] pdo_type;
	logic [N*16-1:0] pdo_volt, pdo_power;
	logic [15:0] min_volt, max_volt, rnd;
	logic [15:0] pv [N];
	logic [15:0] pp [N];
	logic [1:0] pt [N];
	logic [8:0] ex;
	int fails = 0;
	int checks = 0;
	int cyc = 0;

	always_comb
		for (int i = 0; i < N; i++)
		begin
			pdo_volt[i*16 +: 16] = pv[i];
			pdo_power[i*16 +: 16] = pp[i];
			pdo_type[i*2 +: 2] = pt[i];
		end

	power_status_top DUT (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .plug_detected, .connection_state_code, .present_power_role, .cc_pullup_level,
		.advertised_current_setting, .charger_detect_code, .charger_advertise_code, .sel_start,
		.pdo_valid, .pdo_type, .pdo_volt, .pdo_power, .min_volt, .max_volt, .irq);

	port_partner_model u_partner (.clk, .arst_n, .attach, .provide, .top_state, .pull_cmd,
		.plug_detected, .connection_state_code, .present_power_role, .cc_pullup_level);

	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	// Best fitting offer: power, then fixed over variable over the rest, then voltage.
	function automatic logic [8:0] sel_ref(input logic lo);
		logic f;
		logic [2:0] b;
		logic [1:0] rk, br;
		f = 1'b0;
		b = 3'h0;
		br = 2'h0;
		for (int i = 0; i < N; i++)
		begin
			rk = (pt[i] == PDO_FIXED) ? 2'h2 : (pt[i] == PDO_VARIABLE) ? 2'h1 : 2'h0;
			if (pdo_valid[i] && pv[i] >= min_volt && pv[i] <= max_volt && (!f || pp[i] > pp[b] ||
				(pp[i] == pp[b] && (rk > br || (rk == br && (lo ? pv[i] < pv[b] : pv[i] > pv[b]))))))
			begin
				f = 1'b1;
				b = i[2:0];
				br = rk;
			end
		end
		return {f, 5'h00, b};
	endfunction

	task automatic complete_run();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [9:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow_rd;
		// A slow read leaves rready low until rvalid is seen, so the slave must hold its answer.
		forever
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				break;
			if (s_axi_rvalid)
				s_axi_rready <= 1'b1;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rchk(input string n, input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(n, d & m, e);
	endtask

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// A hang ends the run as a failure instead of stalling the simulator.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			complete_run();
		end
	end

	initial
	begin
		{arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sel_start} = '0;
		{attach, provide, s_axi_awaddr, s_axi_araddr, s_axi_wdata, top_state, pull_cmd} = '0;
		{advertised_current_setting, charger_detect_code, charger_advertise_code} = '0;
		{pdo_valid, min_volt, max_volt} = {7'h00, 16'h1388, 16'h3A98};
		s_axi_wstrb = 4'hF;
		slow_rd = 1'b0;
		rnd = 16'h1E78;
		for (int i = 0; i < N; i++)
			{pv[i], pp[i], pt[i]} = '0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rchk("status reset", A_PS, 32'hFFFFFFFF, 32'h0);
		rchk("priority reset", A_CFG, 32'h1, 32'h0);
		s_axi_wstrb <= 4'hE;
		wr(A_CFG, 32'h1);
		s_axi_wstrb <= 4'hF;
		chk("strobe resp", {30'h0, r}, {30'h0, RESP_OKAY});
		rchk("priority strobe", A_CFG, 32'h1, 32'h0);
		rd(10'h3FC);
		chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
		wr(A_PS, 32'hFFFFFFFF);
		chk("status write resp", {30'h0, r}, {30'h0, RESP_OKAY});
		rchk("status after write", A_PS, 32'hFFFFFFFF, 32'h0);
		ed = 4'h0;
		ea = 2'h0;
		for (int i = 0; i < 12; i++)
		begin
			charger_detect_code <= i[3:0];
			charger_advertise_code <= i[1:0];
			ed = (i <= 9) ? i[3:0] : ed;
			ea = (i[1:0] != 2'h3) ? i[1:0] : ea;
			slow_rd = i[0];
			repeat (2) @(posedge clk);
			rchk("charger fields", A_PS, 32'h3F0, {22'h0, ea, ed, 4'h0});
		end
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(A_IMK, 32'h1F);
		repeat (2) @(posedge clk);
		chk("irq unmasked", {31'h0, irq}, 32'h1);
		rchk("events", A_IST, 32'h0C, 32'h0C);
		rchk("events cleared", A_IST, 32'h1F, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		provide <= 1'b1;
		top_state <= 4'h5;
		attach <= 1'b1;
		repeat (14) @(posedge clk);
		rchk("state five", A_PS, 32'h3, 32'h2);
		for (int k = 0; k < 4; k++)
		begin
			rnd = nx(rnd);
			pull_cmd <= rnd[1:0];
			top_state <= 4'h6;
			repeat (4) @(posedge clk);
			rchk("sink", A_PS, 32'hF, {28'h0, rnd[1:0], 2'h3});
		end
		attach <= 1'b0;
		provide <= 1'b0;
		advertised_current_setting <= CUR_3A0;
		repeat (14) @(posedge clk);
		rchk("detached", A_PS, 32'hF, {28'h0, CUR_3A0, 2'h0});
		attach <= 1'b1;
		repeat (14) @(posedge clk);
		advertised_current_setting <= CUR_1A5;
		repeat (4) @(posedge clk);
		rchk("source hold", A_PS, 32'hF, {28'h0, CUR_3A0, 2'h1});
		for (int t = 0; t < 16; t++)
		begin
			for (int i = 0; i < N; i++)
			begin
				rnd = nx(rnd);
				pv[i] <= VT[rnd[1:0]];
				pp[i] <= rnd[2] ? 16'h00C8 : 16'h0064;
				pt[i] <= (t == 1) ? PDO_FIXED : rnd[4:3];
				pdo_valid[i] <= (t == 1) || (t != 0 && rnd[5]);
			end
			wr(A_CFG, {31'h0, t[0]});
			ex = sel_ref(t[0]);
			sel_start <= 1'b1;
			@(posedge clk);
			sel_start <= 1'b0;
			repeat (N + 4) @(posedge clk);
			rchk("selection", A_SEL, ex[8] ? 32'h107 : 32'h100, {23'h0, ex});
		end
		complete_run();
	end
endmodule // power_status_top_tb_top
